// ===== mce_top.sv
// Purpose: Machine-check error code logger with APB register access.
// Assumes: CORE_CLK 125 MHz, RST asynchronous active high, APB slave.
// Notes: Error sources report into banks; software reads and clears them.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
module mce_top
  import mce_pkg::*;
#(
  parameter int NBANKS = 4
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic ERR_VALID,
  input mce_class_t ERR_CLASS,
  input wire logic [7:0] ERR_BANK,
  input wire logic [9:0] ERR_DETAIL,
  input wire logic [1:0] ERR_ACCESS,
  input wire logic [1:0] ERR_TIER,
  input wire logic [3:0] ERR_REQUEST,
  input wire logic [1:0] ERR_PART,
  input wire logic ERR_EXPIRY,
  input wire logic [1:0] ERR_SPACE,
  input wire logic [15:0] ERR_MODEL,
  input wire logic UCODE_PARITY_ERR,
  input wire logic BUS_REINIT_N,
  input wire logic REDUNDANCY_MISMATCH,
  output logic ANY_VALID
);

  // Bank count at the width of the bank selector, so compares against it keep one width.
  localparam logic [7:0] NB8 = 8'(NBANKS);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] reinit_sy;
    logic [1:0] redund_sy;
    logic reinit_d;
    logic redund_d;
    logic [2:0] pend;
    logic model_en;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic any_valid;
  } mce_top_st_t;

  mce_top_st_t st_r;
  mce_top_st_t st_nxt;

  // One carrier per bank between this core and the bank.
  mce_bank_if bif[NBANKS] ();

  // Combinational terms of source selection, address decode and bank read-back.
  logic [15:0] enc_code;
  mce_class_t sel_class;
  logic [9:0] sel_detail;
  logic [7:0] sel_bank;
  logic log_any;
  logic [15:0] b_code[NBANKS];
  logic [15:0] b_model[NBANKS];
  logic [5:0] b_ctl[NBANKS];
  logic [NBANKS-1:0] b_good;
  logic [NBANKS-1:0] b_ovf;
  logic [11:0] a_lo;
  logic [11:0] a_rel;
  logic [7:0] a_bank;
  logic [3:0] a_off;
  logic a_hi_ok;
  logic a_is_bank;
  logic wr_fire;
  logic rd_err;
  logic [31:0] rd_data;
  logic wr_err;
  logic ctl_we;
  logic stat_clr;
  logic reinit_new;
  logic redund_new;

  // ----------------------------------------------------------------
  // Error source selection
  // ----------------------------------------------------------------
  // The general report port is served first; pin events wait in pending flags.
  always_comb begin
    reinit_new = st_r.reinit_sy[1] & ~st_r.reinit_d;
    redund_new = st_r.redund_sy[1] & ~st_r.redund_d;
    sel_class = ERR_CLASS;
    sel_detail = ERR_DETAIL;
    sel_bank = ERR_BANK;
    log_any = 1'b0;
    if (ERR_VALID) begin
      log_any = (ERR_BANK < NB8);
    end else if (st_r.pend != 3'h0) begin
      log_any = 1'b1;
      sel_class = ECL_SIMPLE;
      sel_bank = 8'(SIMPLE_BANK);
      if (st_r.pend[0]) begin
        sel_detail = CODE_REINIT[9:0];
      end else if (st_r.pend[1]) begin
        sel_detail = CODE_REDUND[9:0];
      end else begin
        sel_detail = CODE_UCODE_PAR[9:0];
      end
    end
  end

  // Code builder shared by all banks.
  mce_encode u_enc (
    .err_class(sel_class),
    .detail(sel_detail),
    .acc(ERR_ACCESS),
    .tier(ERR_TIER),
    .req(ERR_REQUEST),
    .part(ERR_PART),
    .expired(ERR_EXPIRY),
    .space(ERR_SPACE),
    .code(enc_code)
  );

  // ----------------------------------------------------------------
  // APB address decode
  // ----------------------------------------------------------------
  // Banks sit at a 16-byte stride above the bank base.
  always_comb begin
    a_lo = PADDR[11:0];
    a_rel = a_lo - OFS_BANK_BASE;
    a_bank = a_rel[11:4];
    a_off = a_rel[3:0];
    a_hi_ok = (PADDR[31:12] == 20'h00000);
    a_is_bank = a_hi_ok && (a_lo >= OFS_BANK_BASE) && (a_bank < NB8);
  end

  // Read data and error for the addressed register.
  always_comb begin
    rd_data = 32'h00000000;
    rd_err = 1'b0;
    if (a_hi_ok && a_lo == OFS_GCTL) begin
      rd_data[GCTL_MODEL_EN] = st_r.model_en;
    end else if (a_hi_ok && a_lo == OFS_GSTAT) begin
      rd_data = 32'(b_good);
    end else if (a_is_bank) begin
      rd_err = 1'b1;
      for (int i = 0; i < NBANKS; i++) begin
        if (a_bank == 8'(i)) begin
          case (a_off)
            OFS_B_CTL: begin
              rd_data = 32'(b_ctl[i]);
              rd_err = 1'b0;
            end
            OFS_B_STAT: begin
              rd_data = {b_model[i], b_code[i]};
              rd_err = 1'b0;
            end
            OFS_B_FLAGS: begin
              rd_data[FLG_GOOD] = b_good[i];
              rd_data[FLG_OVF] = b_ovf[i];
              rd_err = 1'b0;
            end
            default: rd_err = 1'b1;
          endcase
        end
      end
    end else begin
      rd_err = 1'b1;
    end
  end

  // Write checks: status takes only zero, flags and summary are read only.
  always_comb begin
    wr_err = rd_err;
    ctl_we = 1'b0;
    stat_clr = 1'b0;
    if (!rd_err) begin
      if (a_is_bank && a_off == OFS_B_CTL) begin
        ctl_we = PSTRB[0];
      end else if (a_is_bank && a_off == OFS_B_STAT) begin
        stat_clr = (PWDATA == 32'h00000000);
        wr_err = ~stat_clr;
      end else if (a_is_bank || a_lo == OFS_GSTAT) begin
        wr_err = 1'b1;
      end
    end
  end

  // A write takes effect only at the edge that ends the access phase. The answer was
  // registered at setup, so the request has already been judged when PREADY is seen.
  assign wr_fire = PSEL & PENABLE & PWRITE & st_r.pready;

  // ----------------------------------------------------------------
  // Banks
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NBANKS; g++) begin : g_bank
    assign bif[g].log_en = log_any && (sel_bank == 8'(g));
    assign bif[g].log_class = sel_class;
    assign bif[g].log_code = enc_code;
    assign bif[g].log_model = (st_r.model_en && ERR_VALID) ? ERR_MODEL : 16'h0000;
    assign bif[g].clr = wr_fire && !wr_err && stat_clr && (a_bank == 8'(g));
    assign bif[g].ctl_we = wr_fire && !wr_err && ctl_we && (a_bank == 8'(g));
    assign bif[g].ctl_wdata = PWDATA[CTL_W-1:0];
    assign b_code[g] = bif[g].code;
    assign b_model[g] = bif[g].model;
    assign b_ctl[g] = bif[g].ctl;
    assign b_good[g] = bif[g].good;
    assign b_ovf[g] = bif[g].ovf;

    mce_bank u_bank (
      .clk(CORE_CLK),
      .rst(RST),
      .bif(bif[g])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Synchronisers, pending flags (set wins over serve) and APB answer.
  always_comb begin
    st_nxt = st_r;
    st_nxt.reinit_sy = {st_r.reinit_sy[0], ~BUS_REINIT_N};
    st_nxt.redund_sy = {st_r.redund_sy[0], REDUNDANCY_MISMATCH};
    st_nxt.reinit_d = st_r.reinit_sy[1];
    st_nxt.redund_d = st_r.redund_sy[1];
    // A cycle without a general report serves the highest pending pin event.
    if (!ERR_VALID) begin
      if (st_r.pend[0]) begin
        st_nxt.pend[0] = 1'b0;
      end else if (st_r.pend[1]) begin
        st_nxt.pend[1] = 1'b0;
      end else begin
        st_nxt.pend[2] = 1'b0;
      end
    end
    st_nxt.pend = st_nxt.pend | {UCODE_PARITY_ERR, redund_new, reinit_new};
    // The summary output lags the bank flags by one cycle.
    st_nxt.any_valid = |b_good;
    // APB answer: one cycle of PREADY after every setup cycle, no wait states.
    st_nxt.pready = 1'b0;
    st_nxt.pslverr = 1'b0;
    if (PSEL && !PENABLE) begin
      st_nxt.pready = 1'b1;
      st_nxt.pslverr = PWRITE ? wr_err : rd_err;
      st_nxt.prdata = (PWRITE || rd_err) ? 32'h00000000 : rd_data;
    end
    // Global control write.
    if (wr_fire && !wr_err && a_hi_ok && a_lo == OFS_GCTL) begin
      st_nxt.model_en = PWDATA[GCTL_MODEL_EN];
    end
  end

  // State register.
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      st_r <= '{reinit_sy: 2'h0, redund_sy: 2'h0, reinit_d: 1'b0, redund_d: 1'b0, pend: 3'h0,
                model_en: GCTL_RST, prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0,
                any_valid: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a register bit of the state struct.
  assign PRDATA = st_r.prdata;
  assign PREADY = st_r.pready;
  assign PSLVERR = st_r.pslverr;
  assign ANY_VALID = st_r.any_valid;

endmodule : mce_top

// ===== mce_pkg.sv
// Purpose: Shared constants and types for the machine-check error code logger.
// Assumes: 32-bit APB register access, one clock.
// Notes: Code layouts, sub-field encodings, register offsets and reset values.
package mce_pkg;

  // ----------------------------------------------------------------
  // Code widths and fixed codes
  // ----------------------------------------------------------------
  localparam int CODE_W = 16;
  localparam int DATA_W = 32;
  localparam logic [15:0] CODE_NONE = 16'h0000;
  localparam logic [15:0] CODE_UNCLASS = 16'h0001;
  localparam logic [15:0] CODE_UCODE_PAR = 16'h0002;
  localparam logic [15:0] CODE_REINIT = 16'h0003;
  localparam logic [15:0] CODE_REDUND = 16'h0004;
  localparam logic [5:0] PFX_INTERNAL = 6'h01;
  localparam logic [11:0] PFX_TLB = 12'h001;
  localparam logic [7:0] PFX_CACHE = 8'h01;
  localparam logic [4:0] PFX_BUS = 5'h01;

  // ----------------------------------------------------------------
  // Error classes and sub-field encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ECL_UNCLASS = 3'h0,
    ECL_INTERNAL = 3'h1,
    ECL_TLB = 3'h2,
    ECL_CACHE = 3'h3,
    ECL_BUS = 3'h4,
    ECL_SIMPLE = 3'h5
  } mce_class_t;
  localparam logic [1:0] ACC_INSTR = 2'h0;
  localparam logic [1:0] ACC_DATA = 2'h1;
  localparam logic [1:0] ACC_GEN = 2'h2;
  localparam logic [1:0] TIER_L0 = 2'h0;
  localparam logic [1:0] TIER_L1 = 2'h1;
  localparam logic [1:0] TIER_L2 = 2'h2;
  localparam logic [1:0] TIER_GEN = 2'h3;
  localparam logic [3:0] REQ_ERR = 4'h0;
  localparam logic [3:0] REQ_RD = 4'h1;
  localparam logic [3:0] REQ_WR = 4'h2;
  localparam logic [3:0] REQ_EVICT = 4'h7;
  localparam logic [3:0] REQ_SNOOP = 4'h8;
  localparam logic [1:0] PART_GEN = 2'h3;
  localparam logic [1:0] SPC_MEM = 2'h0;
  localparam logic [1:0] SPC_RSVD = 2'h1;
  localparam logic [1:0] SPC_IO = 2'h2;
  localparam logic [1:0] SPC_OTHER = 2'h3;

  // ----------------------------------------------------------------
  // Register map and fields
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_GCTL = 12'h000;
  localparam logic [11:0] OFS_GSTAT = 12'h004;
  localparam logic [11:0] OFS_BANK_BASE = 12'h100;
  localparam int BANK_SH = 4;
  localparam logic [3:0] OFS_B_CTL = 4'h0;
  localparam logic [3:0] OFS_B_STAT = 4'h4;
  localparam logic [3:0] OFS_B_FLAGS = 4'h8;
  localparam int GCTL_MODEL_EN = 0;
  localparam int FLG_GOOD = 0;
  localparam int FLG_OVF = 1;
  localparam int STAT_MODEL_LSB = 16;
  localparam int CTL_W = 6;
  localparam logic [5:0] CTL_RST = 6'h00;
  localparam logic GCTL_RST = 1'b0;
  localparam int SIMPLE_BANK = 0;

endpackage : mce_pkg

// ===== mce_bank_if.sv
// Purpose: Carrier between the logger core and one reporting bank.
// Assumes: Single clock domain.
// Notes: The core drives requests, the bank returns its stored state.
`timescale 1ns/1ps
interface mce_bank_if;
  import mce_pkg::*;
  logic log_en;
  mce_class_t log_class;
  logic [15:0] log_code;
  logic [15:0] log_model;
  logic clr;
  logic ctl_we;
  logic [5:0] ctl_wdata;
  logic [5:0] ctl;
  logic [15:0] code;
  logic [15:0] model;
  logic good;
  logic ovf;
  modport core(output log_en, log_class, log_code, log_model, clr, ctl_we, ctl_wdata,
               input ctl, code, model, good, ovf);
  modport bank(input log_en, log_class, log_code, log_model, clr, ctl_we, ctl_wdata,
               output ctl, code, model, good, ovf);
endinterface : mce_bank_if

// ===== mce_encode.sv
// Purpose: Builds the 16-bit architectural code from class and sub-fields.
// Assumes: Purely combinational; inputs from logic on the same clock.
// Notes: Illegal sub-field values fall back to the generic encodings.
`timescale 1ns/1ps
module mce_encode
  import mce_pkg::*;
(
  input mce_class_t err_class,
  input wire logic [9:0] detail,
  input wire logic [1:0] acc,
  input wire logic [1:0] tier,
  input wire logic [3:0] req,
  input wire logic [1:0] part,
  input wire logic expired,
  input wire logic [1:0] space,
  output logic [15:0] code
);

  logic [1:0] acc_s;
  logic [1:0] tlb_tier;
  logic [1:0] cache_tier;
  logic [3:0] req_c;
  logic [3:0] req_nc;
  logic [1:0] space_s;

  // Sanitise sub-fields, then assemble the code for the class.
  always_comb begin
    acc_s = (acc == 2'h3) ? ACC_GEN : acc;
    tlb_tier = (tier == TIER_L0) ? TIER_L0 : TIER_GEN;
    cache_tier = (tier == TIER_L0) ? TIER_GEN : tier;
    req_c = (req > REQ_SNOOP) ? REQ_ERR : req;
    req_nc = (req_c == REQ_EVICT || req_c == REQ_SNOOP) ? REQ_ERR : req_c;
    space_s = (space == SPC_RSVD) ? SPC_OTHER : space;
    case (err_class)
      ECL_INTERNAL: code = {PFX_INTERNAL, detail};
      ECL_TLB: code = {PFX_TLB, acc_s, tlb_tier};
      ECL_CACHE: code = {PFX_CACHE, req_c, acc_s, cache_tier};
      ECL_BUS: code = {PFX_BUS, part, expired, req_nc, space_s, tier};
      ECL_SIMPLE: begin
        if (detail >= 10'(CODE_UCODE_PAR) && detail <= 10'(CODE_REDUND)) begin
          code = {6'h00, detail};
        end else begin
          code = CODE_UNCLASS;
        end
      end
      default: code = CODE_UNCLASS;
    endcase
  end

endmodule : mce_encode

// ===== mce_bank.sv
// Purpose: One error-reporting bank: control enables, code, model code, flags.
// Assumes: Single clock, asynchronous active-high reset.
// Notes: A new log in the clear cycle wins; a second log sets overflow.
`timescale 1ns/1ps
module mce_bank
  import mce_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  mce_bank_if.bank bif
);

  typedef struct packed {
    logic [5:0] ctl;
    logic [15:0] code;
    logic [15:0] model;
    logic good;
    logic ovf;
  } mce_bank_st_t;

  mce_bank_st_t st_r;
  mce_bank_st_t st_nxt;
  logic enabled;

  // Clear first, then apply a log so a simultaneous event survives.
  always_comb begin
    st_nxt = st_r;
    enabled = st_r.ctl[bif.log_class];
    if (bif.ctl_we) begin
      st_nxt.ctl = bif.ctl_wdata;
    end
    if (bif.clr) begin
      st_nxt.code = CODE_NONE;
      st_nxt.model = 16'h0000;
      st_nxt.good = 1'b0;
      st_nxt.ovf = 1'b0;
    end
    if (bif.log_en && enabled) begin
      if (!st_nxt.good) begin
        st_nxt.code = bif.log_code;
        st_nxt.model = bif.log_model;
        st_nxt.good = 1'b1;
      end else begin
        st_nxt.ovf = 1'b1;
      end
    end
  end

  // State register.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= '{ctl: CTL_RST, code: CODE_NONE, model: 16'h0000, good: 1'b0, ovf: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bif.ctl = st_r.ctl;
  assign bif.code = st_r.code;
  assign bif.model = st_r.model;
  assign bif.good = st_r.good;
  assign bif.ovf = st_r.ovf;

endmodule : mce_bank

// ===== mce_chk_sva.sv
// Purpose: Port-level checks for the error code logger.
// Assumes: One clock domain, reset asynchronous and active high.
// Notes: Code checks look at accepted reads of bank status.
`timescale 1ns/1ps
module mce_chk #(
  parameter int NBANKS = 4
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [31:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR
);
  // ----------------------------------------------------------------
  // Helper terms
  // ----------------------------------------------------------------
  // An accepted status read carries a logged code in its low half.
  wire acc_w = PSEL && PENABLE && PREADY;
  wire rd_st = acc_w && !PWRITE && !PSLVERR && PADDR[11:8] == 4'h1 && PADDR[3:0] == 4'h4 && PADDR[7:4] < NBANKS;
  wire [15:0] c = PRDATA[15:0];

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  // Bus answers come with no wait state and last one cycle.
  ready_timing_a: assert property (PSEL && !PENABLE |=> PREADY) else $error("no answer after setup");
  ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready held too long");
  ready_phase_a: assert property (PREADY |-> PSEL && PENABLE) else $error("ready outside access");
  err_phase_a: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  // Logged codes keep to the documented forms and sub-field values.
  code_form_a: assert property (rd_st |-> c[15:10] == 6'h01 || c[15:11] == 5'h01 || c[15:8] == 8'h01
    || c[15:4] == 12'h001 || c[15:3] == 13'h0) else $error("status code of unknown form");
  simple_range_a: assert property (rd_st && c[15:4] == 12'h0 |-> c[3:0] <= 4'h4)
    else $error("simple code out of range");
  tlb_fields_a: assert property (rd_st && c[15:4] == 12'h001 |-> c[3:2] != 2'h3 && c[1:0] inside {2'h0, 2'h3})
    else $error("bad tlb sub-field");
  cache_fields_a: assert property (rd_st && c[15:8] == 8'h01 |-> c[7:4] <= 4'h8 && c[3:2] != 2'h3 && c[1:0] != 2'h0)
    else $error("bad cache sub-field");
  bus_fields_a: assert property (rd_st && c[15:11] == 5'h01 |-> c[7:4] <= 4'h6 && c[3:2] != 2'h1)
    else $error("bad bus sub-field");

  cover property (rd_st && c[15:11] == 5'h01);
  cover property (rd_st && c[15:4] == 12'h001);
  cover property (PSLVERR);
endmodule : mce_chk

bind mce_top mce_chk #(.NBANKS(NBANKS)) u_chk (.CORE_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PRDATA, .PREADY,
  .PSLVERR);

// ===== mce_sw_model.sv
// Purpose: Software side: bus master, bank setup and clearing.
// Assumes: Zero or more wait states from the slave.
// Notes: A transfer that never completes raises hang.
`timescale 1ns/1ps
module mce_sw_model #(
  parameter int NB = 4
) (
  input wire logic clk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  bit hang = 1'b0;
  bit exc_en = 1'b0;

  // Idle bus from time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
  end

  // ----------------------------------------------------------------
  // One transfer: setup, then access until ready is sampled high.
  // ----------------------------------------------------------------
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd,
                      output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    if (n >= 50) begin
      hang = 1'b1;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // Enables every class in every bank, clears them, then allows the exception.
  task automatic init();
    logic [31:0] r;
    logic e;
    for (int i = 0; i < NB; i++) xfer(1'b1, 32'h100 + 32'(16 * i), 32'hFFFFFFFF, r, e);
    for (int i = 0; i < NB; i++) xfer(1'b1, 32'h104 + 32'(16 * i), 32'h0, r, e);
    exc_en = 1'b1;
  endtask : init
endmodule : mce_sw_model

// ===== tb_top.sv
// Purpose: Self-checking bench for the error code logger.
// Assumes: Bus tasks live in the software model.
// Notes: Each logged error is read back, checked and cleared, except the last, which the second reset clears unread.
`timescale 1ns/1ps
module tb_top;
  import mce_pkg::*;
  typedef struct {mce_class_t c; logic [9:0] d; logic [1:0] a, t; logic [3:0] r; logic [1:0] p; logic x;
    logic [1:0] s; logic [15:0] code;} mce_row_t;
  localparam int NB = 4;
  logic clk = 1'b0;
  logic rst = 1'b1;
  wire psel, pen, pwr, prdy, perr, anyv;
  wire [31:0] pa, pwd, prd;
  logic ev = 1'b0;
  logic [7:0] eb = 8'h00;
  logic [15:0] em = 16'h0000;
  logic upar = 1'b0;
  logic rn = 1'b1;
  logic mm = 1'b0;
  mce_row_t w;
  mce_row_t q;
  int n_mismatch = 0;
  int tests_run = 0;
  // Class, detail, access, tier, request, part, expiry, space, expected code.
  mce_row_t tbl [14] = '{
    '{ECL_UNCLASS, 0, 0, 0, 0, 0, 0, 0, 16'h0001},
    '{ECL_INTERNAL, 10'h155, 0, 0, 0, 0, 0, 0, 16'h0555},
    '{ECL_SIMPLE, 2, 0, 0, 0, 0, 0, 0, 16'h0002},
    '{ECL_SIMPLE, 3, 0, 0, 0, 0, 0, 0, 16'h0003},
    '{ECL_SIMPLE, 4, 0, 0, 0, 0, 0, 0, 16'h0004},
    '{ECL_TLB, 0, 1, 0, 0, 0, 0, 0, 16'h0014},
    '{ECL_TLB, 0, 3, 1, 0, 0, 0, 0, 16'h001B},
    '{ECL_CACHE, 0, 0, 1, 7, 0, 0, 0, 16'h0171},
    '{ECL_CACHE, 0, 2, 0, 8, 0, 0, 0, 16'h018B},
    '{ECL_CACHE, 0, 1, 2, 9, 0, 0, 0, 16'h0106},
    '{ECL_BUS, 0, 0, 2, 3, 1, 1, 2, 16'h0B3A},
    '{ECL_BUS, 0, 0, 3, 8, 2, 0, 1, 16'h0C0F},
    '{ECL_BUS, 0, 0, 1, 1, 0, 0, 0, 16'h0811},
    '{ECL_BUS, 0, 0, 0, 2, 3, 0, 3, 16'h0E2C}};

  initial forever #4 clk = ~clk;

  mce_top #(.NBANKS(NB)) uut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(pa),
    .PWDATA(pwd), .PSTRB(4'hF), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr), .ERR_VALID(ev), .ERR_CLASS(w.c),
    .ERR_BANK(eb), .ERR_DETAIL(w.d), .ERR_ACCESS(w.a), .ERR_TIER(w.t), .ERR_REQUEST(w.r), .ERR_PART(w.p),
    .ERR_EXPIRY(w.x), .ERR_SPACE(w.s), .ERR_MODEL(em), .UCODE_PARITY_ERR(upar), .BUS_REINIT_N(rn),
    .REDUNDANCY_MISMATCH(mm), .ANY_VALID(anyv));
  mce_sw_model #(.NB(NB)) sw (.clk(clk), .psel(psel), .penable(pen), .pwrite(pwr), .paddr(pa), .pwdata(pwd),
    .prdata(prd), .pready(prdy), .pslverr(perr));

  // ----------------------------------------------------------------
  // Checking and bus helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic acc(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [31:0] exp,
                     input logic err);
    logic [31:0] r;
    logic e;
    sw.xfer(wr, a, d, r, e);
    chk(r, exp);
    chk({31'h0, e}, {31'h0, err});
  endtask : acc

  function automatic logic [31:0] ba(input int b, input int o);
    return 32'h100 + 32'(b * 16 + o);
  endfunction : ba

  // Presents one error report for a single cycle.
  task automatic post(input mce_row_t v, input int b, input logic [15:0] m);
    @(posedge clk);
    w <= v;
    eb <= 8'(b);
    em <= m;
    ev <= 1'b1;
    @(posedge clk);
    ev <= 1'b0;
  endtask : post

  // Logs, reads status and flags back, then clears the bank.
  task automatic run(input mce_row_t v, input int b, input logic [15:0] m);
    post(v, b, m);
    acc(1'b0, ba(b, 4), 32'h0, {m, v.code}, 1'b0);
    acc(1'b0, ba(b, 8), 32'h0, 32'h1, 1'b0);
    chk({31'h0, anyv}, 32'h1);
    acc(1'b1, ba(b, 4), 32'h0, 32'h0, 1'b0);
    acc(1'b0, ba(b, 8), 32'h0, 32'h0, 1'b0);
    chk({31'h0, anyv}, 32'h0);
  endtask : run

  task automatic stop_test();
    $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // A transfer that never completes ends the run.
  always @(posedge clk) begin
    if (sw.hang) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    w = tbl[0];
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    post(tbl[5], 0, 16'h0);
    acc(1'b0, ba(0, 4), 32'h0, 32'h0, 1'b0);
    acc(1'b0, ba(0, 0), 32'h0, 32'h0, 1'b0);
    $display("test reset done");
    sw.init();
    acc(1'b0, ba(3, 0), 32'h0, 32'h3F, 1'b0);
    acc(1'b1, 32'h0, 32'h1, 32'h0, 1'b0);
    for (int i = 0; i < 14; i++) run(tbl[i], i % NB, 16'h1000 + 16'(i));
    for (int r = 0; r < 9; r++) begin
      q = '{ECL_CACHE, 0, 1, 1, 4'(r), 0, 0, 0, 16'h0105 | 16'(r * 16)};
      run(q, r % NB, 16'h0);
    end
    $display("test codes done");
    post(tbl[5], 2, 16'h00AA);
    post(tbl[6], 2, 16'h0055);
    acc(1'b0, ba(2, 4), 32'h0, 32'h00AA0014, 1'b0);
    acc(1'b0, ba(2, 8), 32'h0, 32'h3, 1'b0);
    acc(1'b1, ba(2, 4), 32'h0, 32'h0, 1'b0);
    acc(1'b1, ba(1, 4), 32'h5, 32'h0, 1'b1);
    post(tbl[5], 4, 16'h0);
    acc(1'b0, 32'h4, 32'h0, 32'h0, 1'b0);
    acc(1'b0, 32'h50, 32'h0, 32'h0, 1'b1);
    acc(1'b1, 32'h4, 32'h1, 32'h0, 1'b1);
    $display("test overflow done");
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      upar <= (k == 0);
      rn <= (k != 1);
      mm <= (k == 2);
      @(posedge clk);
      upar <= 1'b0;
      repeat (4) @(posedge clk);
      rn <= 1'b1;
      mm <= 1'b0;
      repeat (8) @(posedge clk);
      acc(1'b0, ba(0, 4), 32'h0, 32'(k + 2), 1'b0);
      acc(1'b1, ba(0, 4), 32'h0, 32'h0, 1'b0);
    end
    $display("test pins done");
    post(tbl[5], 1, 16'h0);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    acc(1'b0, ba(1, 8), 32'h0, 32'h0, 1'b0);
    acc(1'b0, ba(1, 0), 32'h0, 32'h0, 1'b0);
    chk({31'h0, anyv}, 32'h0);
    $display("test reset again done");
    stop_test();
  end
endmodule : tb_top
